// ### rtl/lqad_datapath.v
// Qword atomic read-modify-write datapath with local share memory
`include "lqad_defines.vh"

module lqad_datapath (
  // Clock, reset, enable
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  // Request from instruction issue
  input wire req_valid,
  input wire [7:0] req_op,
  input wire [10:0] req_addr,
  input wire [63:0] req_data0,
  input wire [63:0] req_data1,
  input wire [7:0] req_off0,
  input wire [7:0] req_off1,
  input wire [31:0] req_dst,
  output reg req_ready_r,
  // Answer to vector registers
  output reg rsp_valid_r,
  output reg [63:0] rsp_data_r,
  output reg rsp_err_r
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_READ = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;
  localparam [1:0] ST_EXEC2 = 2'b11;

  // ****************************************
  // Storage
  // ****************************************
  reg [63:0] mem [0:`LQAD_DEPTH-1];

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] op_r;
  reg [10:0] addr_r;
  reg [10:0] addr2_r;
  reg [63:0] d0_r;
  reg [63:0] d1_r;
  reg [31:0] dst_r;
  reg [63:0] old_r;

  reg [63:0] new_q;
  reg do_wr;
  reg [31:0] half_ret;
  reg is_half_rd;
  reg is_pair;
  reg known;

  wire [10:0] slot0_a;
  wire [10:0] slot1_a;
  wire [10:0] st0_a;
  wire [10:0] st1_a;
  wire [19:0] sum0;
  wire [19:0] sum1;
  wire [19:0] ssum0;
  wire [19:0] ssum1;
  wire [7:0] old_byte;
  wire [15:0] old_short;
  wire [5:0] byte_pos;
  wire [5:0] short_pos;
  wire [63:0] fp_a;
  wire fp_lt;
  wire fp_eq;
  wire accept;

  // ****************************************
  // Pair slot addresses
  // ****************************************
  // eight-byte slot scaling, 512-byte stride scaling for the strided pair
  assign sum0 = {9'h000, req_addr} +
    ({12'h000, req_off0} << `LQAD_SLOT_SHIFT);
  assign sum1 = {9'h000, req_addr} +
    ({12'h000, req_off1} << `LQAD_SLOT_SHIFT);
  assign ssum0 = {9'h000, req_addr} +
    ({12'h000, req_off0} << `LQAD_STRIDE_SHIFT);
  assign ssum1 = {9'h000, req_addr} +
    ({12'h000, req_off1} << `LQAD_STRIDE_SHIFT);
  // Addresses wrap within the share
  assign slot0_a = sum0[10:0];
  assign slot1_a = sum1[10:0];
  assign st0_a = ssum0[10:0];
  assign st1_a = ssum1[10:0];

  assign accept = ce & req_valid & req_ready_r;

  // ****************************************
  // Lane extraction
  // ****************************************
  assign byte_pos = {addr_r[2:0], 3'b000};
  assign short_pos = {addr_r[2:1], 4'b0000};
  assign old_byte = old_r[byte_pos +: 8];
  assign old_short = old_r[short_pos +: 16];

  // ****************************************
  // Float compare
  // ****************************************
  // Compare-store compares data0, min/max compare data1
  assign fp_a = (op_r == `LQAD_OP_CMPST_F) ? d0_r : d1_r;

  lqad_fp_cmp u_fp_cmp (
    .a(fp_a),
    .b(old_r),
    .a_lt_b(fp_lt),
    .a_eq_b(fp_eq)
  );

  // ****************************************
  // Update value
  // ****************************************
  always @* begin
    new_q = old_r;
    do_wr = 1'b1;
    is_half_rd = 1'b0;
    is_pair = 1'b0;
    known = 1'b1;
    half_ret = dst_r;
    case (op_r)
      `LQAD_OP_ADD, `LQAD_OP_ADD_R: begin
        new_q = old_r + d0_r;
      end
      `LQAD_OP_SUB, `LQAD_OP_SUB_R: begin
        new_q = old_r - d0_r;
      end
      `LQAD_OP_RSUB, `LQAD_OP_RSUB_R: begin
        new_q = d0_r - old_r;
      end
      `LQAD_OP_INC, `LQAD_OP_INC_R: begin
        new_q = (old_r >= d0_r) ? `LQAD_QWORD_RST : old_r + 64'h1;
      end
      // reload limit at zero or above
      `LQAD_OP_DEC, `LQAD_OP_DEC_R: begin
        if ((old_r == `LQAD_QWORD_RST) || (old_r > d0_r)) begin
          new_q = d0_r;
        end else begin
          new_q = old_r - 64'h1;
        end
      end
      `LQAD_OP_SMIN, `LQAD_OP_SMIN_R: begin
        new_q = ($signed(d0_r) < $signed(old_r)) ? d0_r : old_r;
      end
      `LQAD_OP_SMAX, `LQAD_OP_SMAX_R: begin
        new_q = ($signed(d0_r) > $signed(old_r)) ? d0_r : old_r;
      end
      `LQAD_OP_UMIN, `LQAD_OP_UMIN_R: begin
        new_q = (d0_r < old_r) ? d0_r : old_r;
      end
      `LQAD_OP_UMAX, `LQAD_OP_UMAX_R: begin
        new_q = (d0_r > old_r) ? d0_r : old_r;
      end
      `LQAD_OP_AND: begin
        new_q = old_r & d0_r;
      end
      `LQAD_OP_OR: begin
        new_q = old_r | d0_r;
      end
      `LQAD_OP_XOR: begin
        new_q = old_r ^ d0_r;
      end
      `LQAD_OP_MSKOR: begin
        new_q = (old_r & ~d0_r) | d1_r;
      end
      `LQAD_OP_STORE: begin
        new_q = d0_r;
      end
      `LQAD_OP_PAIR, `LQAD_OP_PAIR_ST: begin
        is_pair = 1'b1;
        new_q = (state_r == ST_EXEC2) ? d1_r : d0_r;
      end
      `LQAD_OP_CMPST: begin
        new_q = (old_r == d0_r) ? d1_r : old_r;
      end
      `LQAD_OP_CMPST_F: begin
        new_q = fp_eq ? d1_r : old_r;
      end
      `LQAD_OP_FMIN: begin
        new_q = fp_lt ? d0_r : old_r;
      end
      `LQAD_OP_FMAX: begin
        new_q = fp_lt ? d0_r : old_r;
      end
      `LQAD_OP_B8_HI: begin
        new_q[byte_pos +: 8] = d0_r[`LQAD_HI_BYTE_POS +: 8];
      end
      `LQAD_OP_B16_HI: begin
        new_q[short_pos +: 16] = d0_r[`LQAD_HALF_HI_POS +: 16];
      end
      `LQAD_OP_RU8: begin
        do_wr = 1'b0;
        is_half_rd = 1'b1;
        half_ret[15:0] = {8'h00, old_byte};
      end
      `LQAD_OP_RU8_HI: begin
        do_wr = 1'b0;
        is_half_rd = 1'b1;
        half_ret[31:16] = {8'h00, old_byte};
      end
      `LQAD_OP_RI8: begin
        do_wr = 1'b0;
        is_half_rd = 1'b1;
        half_ret[15:0] = {{8{old_byte[7]}}, old_byte};
      end
      `LQAD_OP_RI8_HI: begin
        do_wr = 1'b0;
        is_half_rd = 1'b1;
        half_ret[31:16] = {{8{old_byte[7]}}, old_byte};
      end
      `LQAD_OP_RU16: begin
        do_wr = 1'b0;
        is_half_rd = 1'b1;
        half_ret[15:0] = old_short;
      end
      `LQAD_OP_RU16_HI: begin
        do_wr = 1'b0;
        is_half_rd = 1'b1;
        half_ret[31:16] = old_short;
      end
      default: begin
        do_wr = 1'b0;
        known = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        state_nxt = is_pair ? ST_EXEC2 : ST_IDLE;
      end
      ST_EXEC2: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // one request in flight locks every address
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      req_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_data_r <= `LQAD_QWORD_RST;
      op_r <= 8'h00;
      addr_r <= 11'h000;
      addr2_r <= 11'h000;
      d0_r <= `LQAD_QWORD_RST;
      d1_r <= `LQAD_QWORD_RST;
      dst_r <= `LQAD_WORD_RST;
      old_r <= `LQAD_QWORD_RST;
    end else if (ce) begin
      state_r <= state_nxt;
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          req_ready_r <= ~req_valid;
          if (req_ready_r && req_valid) begin
            op_r <= req_op;
            d0_r <= req_data0;
            d1_r <= req_data1;
            dst_r <= req_dst;
            if (req_op == `LQAD_OP_PAIR) begin
              addr_r <= slot0_a;
              addr2_r <= slot1_a;
            end else if (req_op == `LQAD_OP_PAIR_ST) begin
              addr_r <= st0_a;
              addr2_r <= st1_a;
            end else begin
              addr_r <= req_addr;
              addr2_r <= req_addr;
            end
          end
        end
        ST_READ: begin
          // Old value captured before any update
          old_r <= mem[addr_r[`LQAD_IDX_HI:`LQAD_IDX_LO]];
        end
        ST_EXEC: begin
          if (!is_pair) begin
            rsp_valid_r <= 1'b1;
            rsp_err_r <= ~known;
            req_ready_r <= 1'b1;
            // Old qword returned, or the merged lane word for the narrow reads
            rsp_data_r <= is_half_rd ? {32'h00000000, half_ret} : old_r;
          end
        end
        ST_EXEC2: begin
          rsp_valid_r <= 1'b1;
          req_ready_r <= 1'b1;
          rsp_data_r <= `LQAD_QWORD_RST;
        end
        default: begin
          req_ready_r <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Memory write port
  // ****************************************
  // Memory content is not reset; software fills it
  always @(posedge ref_clk) begin
    if (ce && do_wr) begin
      if (state_r == ST_EXEC) begin
        mem[addr_r[`LQAD_IDX_HI:`LQAD_IDX_LO]] <= new_q;
      end else if (state_r == ST_EXEC2) begin
        mem[addr2_r[`LQAD_IDX_HI:`LQAD_IDX_LO]] <= new_q;
      end
    end
  end

endmodule

// ### rtl/lqad_defines.vh
// Opcode, field and width constants for the qword atomic datapath
`ifndef LQAD_DEFINES_VH
`define LQAD_DEFINES_VH

// ****************************************
// Widths and field positions
// ****************************************
`define LQAD_OP_W 8
`define LQAD_ADDR_W 11
`define LQAD_IDX_HI 10
`define LQAD_IDX_LO 3
`define LQAD_DEPTH 256
`define LQAD_OFF_W 8
`define LQAD_SLOT_SHIFT 3
`define LQAD_STRIDE_SHIFT 9
`define LQAD_HALF_HI_POS 16
`define LQAD_HI_BYTE_POS 16

// ****************************************
// Reset values
// ****************************************
`define LQAD_QWORD_RST 64'h0000000000000000
`define LQAD_WORD_RST 32'h00000000

// ****************************************
// Opcodes
// ****************************************
`define LQAD_OP_ADD 8'h40
`define LQAD_OP_SUB 8'h41
`define LQAD_OP_RSUB 8'h42
`define LQAD_OP_INC 8'h43
`define LQAD_OP_DEC 8'h44
`define LQAD_OP_SMIN 8'h45
`define LQAD_OP_SMAX 8'h46
`define LQAD_OP_UMIN 8'h47
`define LQAD_OP_UMAX 8'h48
`define LQAD_OP_AND 8'h49
`define LQAD_OP_OR 8'h4a
`define LQAD_OP_XOR 8'h4b
`define LQAD_OP_MSKOR 8'h4c
`define LQAD_OP_STORE 8'h4d
`define LQAD_OP_PAIR 8'h4e
`define LQAD_OP_PAIR_ST 8'h4f
`define LQAD_OP_CMPST 8'h50
`define LQAD_OP_CMPST_F 8'h51
`define LQAD_OP_FMIN 8'h52
`define LQAD_OP_FMAX 8'h53
`define LQAD_OP_B8_HI 8'h54
`define LQAD_OP_B16_HI 8'h55
`define LQAD_OP_RU8 8'h56
`define LQAD_OP_RU8_HI 8'h57
`define LQAD_OP_RI8 8'h58
`define LQAD_OP_RI8_HI 8'h59
`define LQAD_OP_RU16 8'h5a
`define LQAD_OP_RU16_HI 8'h5b
`define LQAD_OP_ADD_R 8'h60
`define LQAD_OP_SUB_R 8'h61
`define LQAD_OP_RSUB_R 8'h62
`define LQAD_OP_INC_R 8'h63
`define LQAD_OP_DEC_R 8'h64
`define LQAD_OP_SMIN_R 8'h65
`define LQAD_OP_SMAX_R 8'h66
`define LQAD_OP_UMIN_R 8'h67
`define LQAD_OP_UMAX_R 8'h68

`endif

// ### rtl/lqad_fp_cmp.v
// Double-precision less-than and equality compare
module lqad_fp_cmp (
  // Operands
  input wire [63:0] a,
  input wire [63:0] b,
  // Results
  output wire a_lt_b,
  output wire a_eq_b
);

  wire a_nan;
  wire b_nan;
  wire any_nan;
  wire both_zero;
  wire mag_lt;
  wire mag_gt;

  assign a_nan = (&a[62:52]) & (|a[51:0]);
  assign b_nan = (&b[62:52]) & (|b[51:0]);
  assign any_nan = a_nan | b_nan;
  // Plus and minus zero are equal
  assign both_zero = ~(|a[62:0]) & ~(|b[62:0]);
  // Denormals order by magnitude, no flush to zero
  assign mag_lt = a[62:0] < b[62:0];
  assign mag_gt = a[62:0] > b[62:0];

  // NaN makes every relation false
  assign a_eq_b = ~any_nan & (both_zero | (a == b));
  assign a_lt_b = ~any_nan & ~both_zero &
    ((a[63] & ~b[63]) |
     (~a[63] & ~b[63] & mag_lt) |
     (a[63] & b[63] & mag_gt));

endmodule

// ### verif/lqad_issue_model.sv
// Issue side model: drives one request at a time and collects the answer
module lqad_issue_model (
  // Clock and answer
  input wire ref_clk,
  input wire req_ready_r,
  input wire rsp_valid_r,
  input wire [63:0] rsp_data_r,
  input wire rsp_err_r,
  // Request
  output reg req_valid,
  output reg [7:0] req_op,
  output reg [10:0] req_addr,
  output reg [63:0] req_data0,
  output reg [63:0] req_data1,
  output reg [7:0] req_off0,
  output reg [7:0] req_off1,
  output reg [31:0] req_dst
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    {req_op, req_addr, req_data0, req_data1} = '0;
    {req_off0, req_off1, req_dst} = '0;
  end
  // ****************************************
  // Request task, called just after an edge
  // ****************************************
  task automatic req(input [7:0] op, input [10:0] a, input [63:0] d0,
    input [63:0] d1, input [7:0] o0, input [7:0] o1, input [31:0] dst,
    output [63:0] rd, output err);
    int n;
    n = 0;
    req_valid = 1'b1;
    {req_op, req_addr, req_data0, req_data1} = {op, a, d0, d1};
    {req_off0, req_off1, req_dst} = {o0, o1, dst};
    while (req_ready_r !== 1'b1 && n < 40) begin
      @(posedge ref_clk) #1;
      n++;
    end
    @(posedge ref_clk) #1;
    req_valid = 1'b0;
    // Released lines must not keep showing the old operands
    {req_data0, req_data1, req_dst} = ~{d0, d1, dst};
    while (rsp_valid_r !== 1'b1 && n < 80) begin
      @(posedge ref_clk) #1;
      n++;
    end
    // A lost answer reads as unknown, so the caller's check fails
    rd = (rsp_valid_r === 1'b1) ? rsp_data_r : 'x;
    err = (rsp_valid_r === 1'b1) ? rsp_err_r : 1'bx;
  endtask
endmodule

// ### verif/lqad_datapath_chk.sv
// Port level assertions for the qword atomic datapath
`include "lqad_defines.vh"
module lqad_datapath_chk (
  // Clock, reset, enable
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  // Request
  input wire req_valid,
  input wire [7:0] req_op,
  input wire [31:0] req_dst,
  input wire req_ready_r,
  // Answer
  input wire rsp_valid_r,
  input wire [63:0] rsp_data_r
);
  wire taken = ce && req_valid && req_ready_r;
  wire pair = req_op == `LQAD_OP_PAIR || req_op == `LQAD_OP_PAIR_ST;
  reg [7:0] op_q;
  reg [31:0] dst_q;
  // Last taken op, so answers can be tied to their cause
  always @(posedge ref_clk) begin
    if (taken) begin
      op_q <= req_op;
      dst_q <= req_dst;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  // Frozen cycles stretch every latency, so they abort attempts
  default disable iff (!rst_n || !ce);
  // ****************************************
  // Assertions
  // ****************************************
  AST_ANS_SINGLE: assert property (taken && !pair |=>
    !rsp_valid_r ##1 !rsp_valid_r ##1 rsp_valid_r) else $error("late answer");
  AST_ANS_PAIR: assert property (taken && pair |=>
    !rsp_valid_r [*3] ##1 (rsp_valid_r && rsp_data_r == 64'h0))
    else $error("bad pair answer");
  AST_BUSY: assert property (taken |=> !req_ready_r [*2])
    else $error("ready while busy");
  AST_READY_BACK: assert property (rsp_valid_r |-> req_ready_r)
    else $error("ready not back");
  AST_PULSE: assert property (rsp_valid_r |=> !rsp_valid_r)
    else $error("answer not a pulse");
  AST_HOLD: assert property (!rsp_valid_r |-> $stable(rsp_data_r))
    else $error("answer data moved");
  AST_LOW_KEEP: assert property (rsp_valid_r && (op_q == `LQAD_OP_RU8 ||
    op_q == `LQAD_OP_RI8 || op_q == `LQAD_OP_RU16) |->
    rsp_data_r[63:16] == {32'h0, dst_q[31:16]}) else $error("upper half lost");
  AST_HIGH_KEEP: assert property (rsp_valid_r && (op_q == `LQAD_OP_RU8_HI ||
    op_q == `LQAD_OP_RI8_HI || op_q == `LQAD_OP_RU16_HI) |->
    rsp_data_r[63:32] == 32'h0 && rsp_data_r[15:0] == dst_q[15:0])
    else $error("lower half lost");
  AST_SIGN_EXT: assert property (rsp_valid_r && op_q == `LQAD_OP_RI8 |->
    rsp_data_r[15:8] == {8{rsp_data_r[7]}}) else $error("bad sign extend");
  AST_ZERO_EXT: assert property (rsp_valid_r && op_q == `LQAD_OP_RU8 |->
    rsp_data_r[15:8] == 8'h00) else $error("bad zero extend");
  COV_PAIR: cover property (taken && pair);
  COV_SLOAD: cover property (rsp_valid_r && op_q == `LQAD_OP_RI8_HI);
  COV_BACK: cover property (rsp_valid_r ##3 rsp_valid_r);
endmodule
bind lqad_datapath lqad_datapath_chk i_chk (.ref_clk, .rst_n, .ce, .req_valid,
  .req_op, .req_dst, .req_ready_r, .rsp_valid_r, .rsp_data_r);

// ### verif/lds_qword_atomic_datapath_bench.sv
// Self-checking bench for the qword atomic datapath
`include "lqad_defines.vh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", nm, e, s); end end
module lds_qword_atomic_datapath_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic req_valid, req_ready_r, rsp_valid_r, rsp_err_r, err;
  logic [7:0] req_op, req_off0, req_off1;
  logic [10:0] req_addr, a_v;
  logic [63:0] req_data0, req_data1, rsp_data_r, rd;
  logic [31:0] req_dst;
  int miscompares = 0;
  int comparisons = 0;
  always #25 ref_clk = ~ref_clk;
  lqad_datapath i_dut (.ref_clk, .rst_n, .ce, .req_valid, .req_op, .req_addr,
    .req_data0, .req_data1, .req_off0, .req_off1, .req_dst, .req_ready_r,
    .rsp_valid_r, .rsp_data_r, .rsp_err_r);
  lqad_issue_model i_issue (.ref_clk, .req_ready_r, .rsp_valid_r, .rsp_data_r,
    .rsp_err_r, .req_valid, .req_op, .req_addr, .req_data0, .req_data1,
    .req_off0, .req_off1, .req_dst);
  // ****************************************
  // Helpers and scenarios
  // ****************************************
  task automatic st(input [7:0] o, input [10:0] a, input [63:0] d);
    i_issue.req(o, a, d, 64'h0, 8'h00, 8'h00, 32'h0, rd, err);
    `CHK("store error", 1'b0, err)
  endtask
  task automatic op(input [7:0] o, input [63:0] d0, input [63:0] d1,
    input [63:0] e);
    i_issue.req(o, a_v, d0, d1, 8'h00, 8'h00, 32'h0, rd, err);
    `CHK("old qword", e, rd)
  endtask
  task automatic ld(input [7:0] o, input [10:0] a, input [63:0] e);
    i_issue.req(o, a, 64'h0, 64'h0, 8'h00, 8'h00, 32'hdeadbeef, rd, err);
    `CHK("load word", e, rd)
  endtask
  task automatic t_arith;
    a_v = 11'h010;
    st(`LQAD_OP_STORE, a_v, 64'h10);
    op(`LQAD_OP_ADD, 64'h5, 64'h0, 64'h10);
    op(`LQAD_OP_SUB_R, 64'h1a, 64'h0, 64'h15);
    op(`LQAD_OP_RSUB, 64'h3, 64'h0, 64'hfffffffffffffffb);
    op(`LQAD_OP_INC_R, 64'h8, 64'h0, 64'h8);
    op(`LQAD_OP_INC, 64'h5, 64'h0, 64'h0);
    op(`LQAD_OP_DEC_R, 64'h7, 64'h0, 64'h1);
    op(`LQAD_OP_DEC, 64'h7, 64'h0, 64'h0);
    op(`LQAD_OP_DEC, 64'h3, 64'h0, 64'h7);
    op(`LQAD_OP_SUB, 64'h0, 64'h0, 64'h3);
    op(`LQAD_OP_RSUB_R, 64'h3, 64'h0, 64'h3);
    op(`LQAD_OP_ADD_R, 64'h0, 64'h0, 64'h0);
    $display("t_arith done");
  endtask
  task automatic t_logic;
    a_v = 11'h020;
    st(`LQAD_OP_STORE, a_v, 64'hfffffffffffffffe);
    op(`LQAD_OP_SMIN, 64'h1, 64'h0, 64'hfffffffffffffffe);
    op(`LQAD_OP_UMIN, 64'h1, 64'h0, 64'hfffffffffffffffe);
    op(`LQAD_OP_SMAX, 64'hfffffffffffffffd, 64'h0, 64'h1);
    op(`LQAD_OP_UMAX, 64'hfffffffffffffffd, 64'h0, 64'h1);
    op(`LQAD_OP_SMIN_R, 64'h5, 64'h0, 64'hfffffffffffffffd);
    op(`LQAD_OP_SMAX_R, 64'h5, 64'h0, 64'hfffffffffffffffd);
    op(`LQAD_OP_UMIN_R, 64'h7, 64'h0, 64'h5);
    op(`LQAD_OP_UMAX_R, 64'h7, 64'h0, 64'h5);
    op(`LQAD_OP_AND, 64'h6, 64'h0, 64'h7);
    op(`LQAD_OP_OR, 64'h9, 64'h0, 64'h6);
    op(`LQAD_OP_XOR, 64'h3c, 64'h0, 64'hf);
    op(`LQAD_OP_MSKOR, 64'hf, 64'h80, 64'h33);
    op(`LQAD_OP_CMPST, 64'hb1, 64'h5, 64'hb0);
    op(`LQAD_OP_CMPST, 64'hb0, 64'h5, 64'hb0);
    op(`LQAD_OP_ADD, 64'h0, 64'h0, 64'h5);
    $display("t_logic done");
  endtask
  task automatic t_float;
    a_v = 11'h040;
    st(`LQAD_OP_STORE, a_v, 64'h3ff0000000000000);
    op(`LQAD_OP_FMIN, 64'h4000000000000000, 64'h3fe0000000000000,
      64'h3ff0000000000000);
    op(`LQAD_OP_FMIN, 64'h0, 64'h7ff8000000000000, 64'h4000000000000000);
    op(`LQAD_OP_FMAX, 64'h0, 64'h7ff0000000000000, 64'h4000000000000000);
    op(`LQAD_OP_FMAX, 64'h1, 64'h8000000000000000, 64'h4000000000000000);
    op(`LQAD_OP_CMPST_F, 64'h1, 64'h0, 64'h1);
    op(`LQAD_OP_CMPST_F, 64'h8000000000000000, 64'h3ff0000000000000,
      64'h0);
    op(`LQAD_OP_CMPST_F, 64'h7ff8000000000000, 64'h0,
      64'h3ff0000000000000);
    op(`LQAD_OP_ADD, 64'h0, 64'h0, 64'h3ff0000000000000);
    $display("t_float done");
  endtask
  task automatic t_pair;
    i_issue.req(`LQAD_OP_PAIR, 11'h100, 64'haa, 64'hbb, 8'h01, 8'h03, 32'h0,
      rd, err);
    `CHK("pair answer", 64'h0, rd)
    // Second slot wraps past the top of the share memory
    i_issue.req(`LQAD_OP_PAIR_ST, 11'h008, 64'hcc, 64'hdd, 8'h01, 8'h04, 32'h0,
      rd, err);
    `CHK("pair answer", 64'h0, rd)
    ld(`LQAD_OP_ADD, 11'h108, 64'haa);
    ld(`LQAD_OP_ADD, 11'h118, 64'hbb);
    ld(`LQAD_OP_ADD, 11'h208, 64'hcc);
    ld(`LQAD_OP_ADD, 11'h008, 64'hdd);
    $display("t_pair done");
  endtask
  task automatic t_half;
    a_v = 11'h030;
    st(`LQAD_OP_STORE, a_v, 64'h1122334455667788);
    st(`LQAD_OP_B8_HI, 11'h031, 64'h00c30000);
    st(`LQAD_OP_B16_HI, 11'h034, 64'h9abc0000);
    ld(`LQAD_OP_RU8, 11'h030, 64'h00000000dead0088);
    ld(`LQAD_OP_RU8_HI, 11'h031, 64'h0000000000c3beef);
    ld(`LQAD_OP_RI8, 11'h031, 64'h00000000deadffc3);
    ld(`LQAD_OP_RI8_HI, 11'h030, 64'h00000000ff88beef);
    ld(`LQAD_OP_RU16, 11'h034, 64'h00000000dead9abc);
    ld(`LQAD_OP_RU16_HI, 11'h030, 64'h00000000c388beef);
    op(`LQAD_OP_ADD, 64'h0, 64'h0, 64'h11229abc5566c388);
    // Unknown opcode must leave memory alone
    op(8'h5c, 64'h1, 64'h1, 64'h11229abc5566c388);
    `CHK("error flag", 1'b1, err)
    op(`LQAD_OP_ADD, 64'h0, 64'h0, 64'h11229abc5566c388);
    `CHK("error flag", 1'b0, err)
    $display("t_half done");
  endtask
  task automatic t_ce;
    a_v = 11'h050;
    st(`LQAD_OP_STORE, a_v, 64'h21);
    fork
      op(`LQAD_OP_ADD, 64'h2, 64'h0, 64'h21);
      begin
        @(posedge ref_clk);
        #1 ce = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        // Enable low must hold the unit busy
        `CHK("frozen ready", 1'b0, req_ready_r)
        ce = 1'b1;
      end
    join
    op(`LQAD_OP_ADD, 64'h0, 64'h0, 64'h23);
    $display("t_ce done");
  endtask
  task automatic test_done;
    $display("Checked %0d, mismatched %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // Ready first rises one edge after release
    @(posedge ref_clk) #1;
    t_arith();
    t_logic();
    t_float();
    t_pair();
    t_half();
    t_ce();
    test_done();
  end
  // About 60 requests of three cycles each (four for pairs), with a wide margin
  initial begin
    #(50 * 3000);
    miscompares++;
    test_done();
  end
endmodule
